/* hdl/adc_result_window_regs.sv */
`timescale 1ns/1ps
`include "adc_regs_consts.svh"
module adc_result_window_regs #(
    parameter int CONV_DIV = 4
) (
    // Clock and reset
    input  wire logic                mclk_i,
    input  wire logic                arst_n_i,
    // Register port
    input  wire adc_regs_pkg::addr_t reg_addr_i,
    input  wire adc_regs_pkg::word_t reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output adc_regs_pkg::word_t      reg_rdata_o,
    // Conversion core
    input  wire logic                conv_valid_i,
    input  wire adc_regs_pkg::word_t conv_raw_i,
    input  wire logic                left_align_i,
    input  wire logic                oversample_i,
    input  wire logic                correction_on_i,
    input  wire logic                window_enable_i,
    input  wire logic                converter_enable_i,
    input  wire logic                soft_reset_i,
    input  wire logic                debug_halt_i,
    // Status and trims out
    output logic                     conv_halt_o,
    output logic [2:0]               bias_trim_o,
    output logic [7:0]               linearity_trim_o,
    output logic                     result_ready_flag_o,
    output logic                     overrun_o,
    output logic                     window_hit_o,
    output logic                     sync_done_flag_o,
    output logic                     sync_pending_o
);
    import adc_regs_pkg::*;

    shaper_if sh ();

    logic        rst_meta;
    logic        rst_n;
    logic [7:0]  div_cnt;
    logic        conv_tick;
    word_t       conv_value;
    word_t       win_low_sw;
    word_t       win_high_sw;
    word_t       win_low_eff;
    word_t       win_high_eff;
    word_t       gain_trim;
    word_t       offset_trim;
    word_t       analog_trim;
    logic        run_while_halted;
    logic        halted;
    logic        take;
    logic        unread;
    logic        win_arm;
    logic        soft_q;
    sync_fsm_t   sync_state;
    sync_fsm_t   next_sync_state;
    logic [1:0]  sync_cnt;
    logic        sync_done_pulse;
    logic        win_wr;
    logic        rd_result;
    logic        wr_flags;

    // Reset release through two flops; only the second is used
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Conversion clock as an enable pulse every CONV_DIV cycles
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == 8'(CONV_DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign conv_tick = (div_cnt == 8'(CONV_DIV - 1));

    // Access decode
    assign win_wr    = reg_wr_i && !soft_reset_i
                       && (reg_addr_i == `OFS_WIN_LOW || reg_addr_i == `OFS_WIN_HIGH);
    assign rd_result = reg_rd_i && (reg_addr_i == `OFS_CONV_VALUE);
    assign wr_flags  = reg_wr_i && (reg_addr_i == `OFS_FLAGS);

    // Debug halt gates conversion intake unless allowed to run
    assign halted = debug_halt_i && !run_while_halted;
    assign take   = conv_valid_i && conv_tick && !halted;

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_halt_o <= 1'b0;
        end else begin
            conv_halt_o <= halted;
        end
    end

    // Halt policy: locked against bus writes while the converter runs; soft reset clears it at any time
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            run_while_halted <= 1'b0;
        end else if (soft_reset_i) begin
            run_while_halted <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `OFS_HALT && !converter_enable_i) begin
            run_while_halted <= reg_wdata_i[`HALT_RUN_BIT];
        end
    end

    // Correction and analog trim registers, plain storage
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            gain_trim   <= `RST_WORD;
            offset_trim <= `RST_WORD;
            analog_trim <= `RST_WORD;
        end else if (soft_reset_i) begin
            gain_trim   <= `RST_WORD;
            offset_trim <= `RST_WORD;
            analog_trim <= `RST_WORD;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `OFS_GAIN) begin
                gain_trim <= reg_wdata_i & `TRIM12_MASK;
            end
            if (reg_addr_i == `OFS_OFFSET) begin
                offset_trim <= reg_wdata_i & `TRIM12_MASK;
            end
            if (reg_addr_i == `OFS_TRIM) begin
                analog_trim <= reg_wdata_i & `TRIM_MASK;
            end
        end
    end
    assign bias_trim_o      = analog_trim[10:8];
    assign linearity_trim_o = analog_trim[7:0];

    // Window limits: bus copy now, working copy after the transfer
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            win_low_sw  <= `RST_WORD;
            win_high_sw <= `RST_WORD;
        end else if (soft_reset_i) begin
            win_low_sw  <= `RST_WORD;
            win_high_sw <= `RST_WORD;
        end else if (reg_wr_i && reg_addr_i == `OFS_WIN_LOW) begin
            win_low_sw  <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == `OFS_WIN_HIGH) begin
            win_high_sw <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            win_low_eff  <= `RST_WORD;
            win_high_eff <= `RST_WORD;
        end else if (soft_reset_i) begin
            win_low_eff  <= `RST_WORD;
            win_high_eff <= `RST_WORD;
        end else if (sync_done_pulse) begin
            win_low_eff  <= win_low_sw;
            win_high_eff <= win_high_sw;
        end
    end

    // Transfer state: a new write restarts the count so the last value wins
    always_comb begin
        next_sync_state = sync_state;
        case (sync_state)
            SYNC_IDLE: if (win_wr) next_sync_state = SYNC_BUSY;
            SYNC_BUSY: if (!win_wr && conv_tick && sync_cnt == 2'h1) next_sync_state = SYNC_IDLE;
            default:   next_sync_state = SYNC_IDLE;
        endcase
    end
    assign sync_done_pulse = (sync_state == SYNC_BUSY) && (next_sync_state == SYNC_IDLE);

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_state <= SYNC_IDLE;
            sync_cnt   <= 2'h0;
        end else if (soft_reset_i) begin
            sync_state <= SYNC_IDLE;
            sync_cnt   <= 2'h0;
        end else begin
            sync_state <= next_sync_state;
            if (win_wr) begin
                sync_cnt <= `SYNC_TICKS;
            end else if (sync_state == SYNC_BUSY && conv_tick) begin
                sync_cnt <= sync_cnt - 2'h1;
            end
        end
    end
    assign sync_pending_o = (sync_state == SYNC_BUSY);

    // Shaper hookup
    assign sh.raw           = conv_raw_i;
    assign sh.raw_valid     = take;
    assign sh.mode          = oversample_i ? ALIGN_OVER : (left_align_i ? ALIGN_LEFT : ALIGN_RIGHT);
    assign sh.correction_on = correction_on_i;
    assign sh.gain_val      = gain_trim[11:0];
    assign sh.offset_val    = offset_trim[11:0];
    assign sh.win_en        = window_enable_i;
    assign sh.win_low       = win_low_eff;
    assign sh.win_high      = win_high_eff;

    result_shaper u_shaper (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n),
        .sh      (sh)
    );

    // Result store and unread tracking
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_value <= `RST_WORD;
            unread     <= 1'b0;
        end else if (soft_reset_i) begin
            conv_value <= `RST_WORD;
            unread     <= 1'b0;
        end else if (sh.result_valid) begin
            conv_value <= sh.result;
            unread     <= 1'b1;
        end else if (rd_result) begin
            unread     <= 1'b0;
        end
    end

    // Window match waits for the next conversion tick
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            win_arm <= 1'b0;
        end else if (soft_reset_i) begin
            win_arm <= 1'b0;
        end else if (sh.result_valid && sh.win_match) begin
            win_arm <= 1'b1;
        end else if (conv_tick) begin
            win_arm <= 1'b0;
        end
    end

    // Event flags: a set in the clearing cycle wins
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_flag_o <= 1'b0;
            overrun_o           <= 1'b0;
            window_hit_o        <= 1'b0;
            sync_done_flag_o    <= 1'b0;
            soft_q              <= 1'b0;
        end else begin
            soft_q <= soft_reset_i;
            if (soft_reset_i) begin
                result_ready_flag_o <= 1'b0;
                overrun_o           <= 1'b0;
                window_hit_o        <= 1'b0;
                sync_done_flag_o    <= 1'b0;
            end else begin
                result_ready_flag_o <= sh.result_valid || (result_ready_flag_o && !rd_result
                    && !(wr_flags && reg_wdata_i[`FLG_READY]));
                overrun_o <= (sh.result_valid && unread)
                    || (overrun_o && !(wr_flags && reg_wdata_i[`FLG_OVERRUN]));
                window_hit_o <= (win_arm && conv_tick) || (window_hit_o && !rd_result
                    && !(wr_flags && reg_wdata_i[`FLG_WINHIT]));
                sync_done_flag_o <= sync_done_pulse
                    || (sync_done_flag_o && !(wr_flags && reg_wdata_i[`FLG_SYNCDONE]));
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= `RST_WORD;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= `RST_WORD;
        end else begin
            case (reg_addr_i)
                `OFS_FLAGS:      reg_rdata_o <= {12'h000, sync_done_flag_o, window_hit_o,
                                                 overrun_o, result_ready_flag_o};
                `OFS_STATUS:     reg_rdata_o <= {8'h00, sync_pending_o, 7'h00};
                `OFS_CONV_VALUE: reg_rdata_o <= conv_value;
                `OFS_WIN_LOW:    reg_rdata_o <= win_low_sw;
                `OFS_WIN_HIGH:   reg_rdata_o <= win_high_sw;
                `OFS_GAIN:       reg_rdata_o <= gain_trim;
                `OFS_OFFSET:     reg_rdata_o <= offset_trim;
                `OFS_TRIM:       reg_rdata_o <= analog_trim;
                `OFS_HALT:       reg_rdata_o <= {15'h0000, run_while_halted};
                default:         reg_rdata_o <= `RST_WORD;
            endcase
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    chk_pending_on_write: assert property (
        win_wr |=> sync_pending_o ##0 win_low_eff == $past(win_low_eff))
        else $error("Window write did not raise pending");
    chk_done_on_fall: assert property (
        ($fell(sync_pending_o) && !soft_q) |-> sync_done_flag_o)
        else $error("Pending fell without sync done");
    chk_take_to_result: assert property (
        take |=> sh.result_valid ##1 conv_value == $past(sh.result))
        else $error("Conversion not stored two cycles after intake");
    chk_right_align: assert property (
        (sh.result_valid && !$past(left_align_i) && !$past(oversample_i) && !soft_reset_i)
        |=> conv_value[15:12] == 4'h0)
        else $error("Right aligned result has upper bits set");
    chk_left_align: assert property (
        (sh.result_valid && $past(left_align_i) && !$past(oversample_i) && !soft_reset_i)
        |=> conv_value[3:0] == 4'h0)
        else $error("Left aligned result has low nibble set");
    chk_ready_set: assert property (
        (sh.result_valid && !soft_reset_i) |=> result_ready_flag_o)
        else $error("Ready flag missed a new result");
    chk_read_clears: assert property (
        (rd_result && !sh.result_valid && !(win_arm && conv_tick) && !soft_reset_i)
        |=> !result_ready_flag_o && !window_hit_o)
        else $error("Result read did not clear flags");
    chk_overrun_set: assert property (
        (sh.result_valid && unread && !soft_reset_i) |=> overrun_o)
        else $error("Overrun not flagged");
    chk_winhit_tick: assert property (
        (win_arm && conv_tick && !soft_reset_i) |=> window_hit_o)
        else $error("Window hit not set on conversion tick");
    chk_halt_locked: assert property (
        (converter_enable_i && !soft_reset_i) |=> $stable(run_while_halted))
        else $error("Halt policy changed while enabled");
    chk_halted_blocks: assert property (
        (halted && conv_valid_i && conv_tick) |=> !sh.result_valid)
        else $error("Conversion taken while halted");

    cov_overrun: cover property (sh.result_valid && unread);
    cov_sync_done: cover property ($fell(sync_pending_o));
    cov_window_hit: cover property ($rose(window_hit_o));
    cov_left_result: cover property (take && left_align_i && !oversample_i);
endmodule

/* hdl/result_shaper.sv */
`timescale 1ns/1ps
`include "adc_regs_consts.svh"
module result_shaper (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Settings in, result out
    shaper_if.shape   sh
);
    import adc_regs_pkg::*;

    logic signed [17:0] diff;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    word_t              limit;
    word_t              value;
    word_t              aligned;

    // Offset then gain, clamped to the active result width
    always_comb begin
        diff   = $signed({2'b00, sh.raw}) - $signed({{6{sh.offset_val[11]}}, sh.offset_val});
        prod   = 32'(diff) * $signed({20'h00000, sh.gain_val});
        scaled = prod >>> `GAIN_SHIFT;
        limit  = (sh.mode == ALIGN_OVER) ? `FULL_LIMIT : `SINGLE_LIMIT;
        if (!sh.correction_on) begin
            value = sh.raw & limit;
        end else if (scaled < 0) begin
            value = `RST_WORD;
        end else if (scaled > $signed({16'h0000, limit})) begin
            value = limit;
        end else begin
            value = scaled[15:0];
        end
    end

    // Placement in the 16-bit word
    always_comb begin
        case (sh.mode)
            ALIGN_LEFT:  aligned = {value[11:0], 4'h0};
            ALIGN_OVER:  aligned = value;
            ALIGN_RIGHT: aligned = {4'h0, value[11:0]};
            default:     aligned = {4'h0, value[11:0]};
        endcase
    end

    // Result register, valid pulse and window match
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh.result       <= `RST_WORD;
            sh.result_valid <= 1'b0;
            sh.win_match    <= 1'b0;
        end else begin
            sh.result_valid <= sh.raw_valid;
            if (sh.raw_valid) begin
                sh.result    <= aligned;
                sh.win_match <= sh.win_en && (value >= sh.win_low)
                                && (value <= sh.win_high);
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_unity_gain_pass: assert property (
        (sh.raw_valid && sh.correction_on && sh.gain_val == 12'h800 && sh.offset_val == 12'h000
         && sh.mode == ALIGN_RIGHT && sh.raw <= 16'h0FFF)
        |=> sh.result == $past(sh.raw))
        else $error("Unity gain did not pass the raw value");
    chk_signed_offset: assert property (
        (sh.raw_valid && sh.correction_on && sh.gain_val == 12'h800 && sh.offset_val == 12'hFFF
         && sh.mode == ALIGN_RIGHT && sh.raw == 16'h0000)
        |=> sh.result == 16'h0001)
        else $error("Negative offset not applied as two's complement");
endmodule

/* pkg/adc_regs_consts.svh */
// What this block does
// - Pending bit sets when a cross-domain register transfer starts, clears when done.
// - Read-only 16-bit conversion value register holds up to sixteen result bits.
// - Single conversion without averaging yields 12 bits, aligned by left_align.
// - Left aligned: upper eight bits in [15:8], lower four in [7:4].
// - Right aligned, no oversampling: result sits in bits [11:0].
// - Oversampling: result spans bits [15:0] as averaging sets it.
// - Lower window limit is the monitor's lower bound when enabled.
// - Upper window limit is the monitor's upper bound when enabled.
// - With correction on, subtract offset trim before storing the result.
// - Offset trim is a signed 12-bit two's complement value.
// - run_while_halted changes only while the converter is disabled; soft reset here also clears it while enabled.
// - run_while_halted 0 halts in debug; 1 keeps converting.
// - Ready flag sets on new result; write-one or result read clears it.
// - Overrun flag sets when a result lands before the previous was read.
// - Window hit sets one conversion tick after a match; read or write-one clears.
// - Sync done sets on pending falling, except when caused by software reset.
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH

`define OFS_FLAGS       8'h18
`define OFS_STATUS      8'h19
`define OFS_CONV_VALUE  8'h1A
`define OFS_WIN_LOW     8'h1C
`define OFS_WIN_HIGH    8'h20
`define OFS_GAIN        8'h24
`define OFS_OFFSET      8'h26
`define OFS_TRIM        8'h28
`define OFS_HALT        8'h2A

`define FLG_READY       0
`define FLG_OVERRUN     1
`define FLG_WINHIT      2
`define FLG_SYNCDONE    3
`define STATUS_PENDING  7
`define HALT_RUN_BIT    0

`define RST_WORD        16'h0000
`define RST_BYTE        8'h00
`define TRIM12_MASK     16'h0FFF
`define TRIM_MASK       16'h07FF
`define SINGLE_LIMIT    16'h0FFF
`define FULL_LIMIT      16'hFFFF
`define GAIN_SHIFT      11
`define SYNC_TICKS      2'h2

`endif

/* pkg/adc_regs_pkg.sv */
package adc_regs_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  addr_t;
    typedef enum logic [0:0] {
        SYNC_IDLE = 1'b0,
        SYNC_BUSY = 1'b1
    } sync_fsm_t;
    typedef enum logic [1:0] {
        ALIGN_RIGHT = 2'b00,
        ALIGN_LEFT  = 2'b01,
        ALIGN_OVER  = 2'b10
    } align_mode_t;
endpackage

/* pkg/shaper_if.sv */
`timescale 1ns/1ps
interface shaper_if;
    import adc_regs_pkg::*;
    word_t       raw;
    logic        raw_valid;
    align_mode_t mode;
    logic        correction_on;
    logic [11:0] gain_val;
    logic [11:0] offset_val;
    logic        win_en;
    word_t       win_low;
    word_t       win_high;
    word_t       result;
    logic        result_valid;
    logic        win_match;
    modport ctrl  (output raw, raw_valid, mode, correction_on, gain_val, offset_val,
                   win_en, win_low, win_high, input result, result_valid, win_match);
    modport shape (input raw, raw_valid, mode, correction_on, gain_val, offset_val,
                   win_en, win_low, win_high, output result, result_valid, win_match);
endinterface

/* tb/tb.sv */
`timescale 1ns/1ps
`include "adc_regs_consts.svh"
module tb;
    import adc_regs_pkg::*;
    localparam int DIV = 4;
    typedef struct {logic la; logic ov; logic co; word_t raw; word_t exp;} row_t;
    logic        mclk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, conv_valid_i = 0;
    logic        left_align_i = 0, oversample_i = 0, correction_on_i = 0, window_enable_i = 0;
    logic        converter_enable_i = 0, soft_reset_i = 0, debug_halt_i = 0;
    addr_t       reg_addr_i = 8'h00;
    word_t       reg_wdata_i = 16'h0000, conv_raw_i = 16'h0000, reg_rdata_o, d;
    logic        conv_halt_o, result_ready_flag_o, overrun_o, window_hit_o;
    logic        sync_done_flag_o, sync_pending_o;
    logic [2:0]  bias_trim_o;
    logic [7:0]  linearity_trim_o;
    int          errors = 0, cmp_count = 0, cycles = 0;
    // Gain 0x400 is one half, offset 0xFFE is minus two
    row_t        rows[6] = '{'{0, 0, 0, 16'hFABC, 16'h0ABC}, '{1, 0, 0, 16'h0ABC, 16'hABC0},
                             '{0, 1, 0, 16'hFABC, 16'hFABC}, '{1, 1, 0, 16'h1234, 16'h1234},
                             '{0, 0, 1, 16'h0100, 16'h0081}, '{1, 0, 1, 16'h0100, 16'h0810}};
    word_t       wraw[4] = '{16'h0100, 16'h0200, 16'h00FF, 16'h0201};
    logic        whit[4] = '{1, 1, 0, 0};
    addr_t       offs[7] = '{`OFS_CONV_VALUE, `OFS_WIN_LOW, `OFS_WIN_HIGH, `OFS_GAIN,
                             `OFS_OFFSET, `OFS_TRIM, `OFS_HALT};

    adc_result_window_regs #(.CONV_DIV(DIV)) i_adc_result_window_regs (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .conv_valid_i(conv_valid_i), .conv_raw_i(conv_raw_i),
        .left_align_i(left_align_i), .oversample_i(oversample_i),
        .correction_on_i(correction_on_i), .window_enable_i(window_enable_i),
        .converter_enable_i(converter_enable_i), .soft_reset_i(soft_reset_i),
        .debug_halt_i(debug_halt_i), .conv_halt_o(conv_halt_o), .bias_trim_o(bias_trim_o),
        .linearity_trim_o(linearity_trim_o), .result_ready_flag_o(result_ready_flag_o),
        .overrun_o(overrun_o), .window_hit_o(window_hit_o),
        .sync_done_flag_o(sync_done_flag_o), .sync_pending_o(sync_pending_o));

    // Clock at 250 MHz
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // A hang costs far more than the few hundred cycles the tests need
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    task automatic chk_w(input string n, input word_t e, input word_t g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_b(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic wr(input addr_t a, input word_t v);
        @(posedge mclk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge mclk_i);
        reg_wr_i <= 0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input addr_t a, output word_t v);
        @(posedge mclk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 0;
        #1 v = reg_rdata_o;
    endtask

    // Valid held for DIV edges meets exactly one conversion tick
    task automatic conv(input word_t raw);
        @(posedge mclk_i);
        conv_valid_i <= 1;
        conv_raw_i <= raw;
        repeat (DIV) @(posedge mclk_i);
        conv_valid_i <= 0;
        repeat (3) @(posedge mclk_i);
        #1 chk_b("ready", 1, result_ready_flag_o);
    endtask

    task automatic wsync(input addr_t a, input word_t v);
        int k;
        wr(a, v);
        chk_b("pending", 1, sync_pending_o);
        rd(`OFS_STATUS, d);
        chk_w("status", 16'h0080, d);
        for (k = 0; k < 40 && sync_pending_o !== 1'b0; k++) begin
            @(posedge mclk_i);
            #1;
        end
        @(posedge mclk_i);
        #1 chk_b("sync_done", 1, sync_done_flag_o);
        wr(`OFS_FLAGS, 16'h0008);
        chk_b("sync_done", 0, sync_done_flag_o);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk_i);
        arst_n_i <= 1;
        repeat (3) @(posedge mclk_i);
        foreach (offs[i]) begin
            rd(offs[i], d);
            chk_w("reset value", 16'h0000, d);
        end
        wr(8'h30, 16'hFFFF);
        rd(8'h30, d);
        chk_w("unmapped", 16'h0000, d);
        wr(`OFS_CONV_VALUE, 16'h5555);
        rd(`OFS_CONV_VALUE, d);
        chk_w("value read only", 16'h0000, d);
        wr(`OFS_TRIM, 16'hF5A5);
        rd(`OFS_TRIM, d);
        chk_w("trim", 16'h05A5, d);
        chk_w("bias", 16'h0005, {13'h0, bias_trim_o});
        chk_w("linearity", 16'h00A5, {8'h00, linearity_trim_o});
        wr(`OFS_GAIN, 16'hF400);
        wr(`OFS_OFFSET, 16'hFFFE);
        rd(`OFS_OFFSET, d);
        chk_w("offset", 16'h0FFE, d);
        $display("register test done");
        // Ordinary conversions, one row each
        foreach (rows[i]) begin
            left_align_i <= rows[i].la;
            oversample_i <= rows[i].ov;
            correction_on_i <= rows[i].co;
            conv(rows[i].raw);
            rd(`OFS_CONV_VALUE, d);
            chk_w("value", rows[i].exp, d);
            chk_b("ready", 0, result_ready_flag_o);
            chk_b("overrun", 0, overrun_o);
        end
        $display("conversion rows done");
        // Unity gain with offset minus one, then with no offset
        wr(`OFS_GAIN, 16'h0800);
        wr(`OFS_OFFSET, 16'h0FFF);
        left_align_i <= 0;
        conv(16'h0000);
        rd(`OFS_CONV_VALUE, d);
        chk_w("minus one offset", 16'h0001, d);
        wr(`OFS_OFFSET, 16'h0000);
        conv(16'h0ABC);
        rd(`OFS_CONV_VALUE, d);
        chk_w("unity gain", 16'h0ABC, d);
        $display("correction test done");
        conv(16'h0010);
        conv(16'h0020);
        chk_b("overrun", 1, overrun_o);
        wr(`OFS_FLAGS, 16'h0002);
        chk_b("overrun", 0, overrun_o);
        wr(`OFS_FLAGS, 16'h0001);
        chk_b("ready", 0, result_ready_flag_o);
        $display("overrun test done");
        window_enable_i <= 1;
        wsync(`OFS_WIN_LOW, 16'h0100);
        wsync(`OFS_WIN_HIGH, 16'h0200);
        foreach (wraw[i]) begin
            conv(wraw[i]);
            repeat (2 * DIV) @(posedge mclk_i);
            #1 chk_b("window_hit", whit[i], window_hit_o);
            rd(`OFS_CONV_VALUE, d);
            chk_b("window_hit", 0, window_hit_o);
        end
        $display("window test done");
        converter_enable_i <= 1;
        wr(`OFS_HALT, 16'h0001);
        rd(`OFS_HALT, d);
        chk_w("halt locked", 16'h0000, d);
        converter_enable_i <= 0;
        wr(`OFS_HALT, 16'h0001);
        rd(`OFS_HALT, d);
        chk_w("halt", 16'h0001, d);
        debug_halt_i <= 1;
        repeat (2) @(posedge mclk_i);
        #1 chk_b("conv_halt", 0, conv_halt_o);
        wr(`OFS_HALT, 16'h0000);
        repeat (2) @(posedge mclk_i);
        #1 chk_b("conv_halt", 1, conv_halt_o);
        // Halted: a result offered across a whole tick must be dropped
        @(posedge mclk_i);
        conv_valid_i <= 1;
        repeat (DIV) @(posedge mclk_i);
        conv_valid_i <= 0;
        repeat (3) @(posedge mclk_i);
        #1 chk_b("halted intake", 0, result_ready_flag_o);
        debug_halt_i <= 0;
        $display("halt test done");
        // Software reset mid-transfer must not raise sync done
        wr(`OFS_WIN_HIGH, 16'h0300);
        soft_reset_i <= 1;
        @(posedge mclk_i);
        soft_reset_i <= 0;
        @(posedge mclk_i);
        #1 chk_b("pending", 0, sync_pending_o);
        repeat (3 * DIV) @(posedge mclk_i);
        #1 chk_b("sync_done", 0, sync_done_flag_o);
        rd(`OFS_WIN_HIGH, d);
        chk_w("win high", 16'h0000, d);
        $display("soft reset test done");
        // Mid-run hardware reset; first access waits out the reset synchroniser
        wr(`OFS_TRIM, 16'h0123);
        @(posedge mclk_i);
        arst_n_i <= 0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1;
        repeat (3) @(posedge mclk_i);
        #1 chk_w("trim after reset", 16'h0000, {5'h00, bias_trim_o, linearity_trim_o});
        rd(`OFS_TRIM, d);
        chk_w("trim read after reset", 16'h0000, d);
        $display("hardware reset test done");
        summarize();
    end
endmodule
